// ==== design/rfp_top.sv ====
// Flag output, device reset and test-mode-select pin logic
`timescale 1ns/1ps
`include "rfp_regs.svh"

// Operation
// RULE1: Flag high on set instruction; low on clear or status bit 13 zero.
// RULE2: Flag always driven; high impedance only during boundary scan.
// RULE3: Reset halts execution, loads reset vector into PC, clears state.
// RULE4: On release fetch reset vector at FFFF00h, branching to boot loader.
// RULE5: Reset pull-up follows its control bit but is forced on in reset.
// RULE6: Mode select is sampled into test logic on rising test clock.
// RULE7: Mode select pull-up is switched by software through its control bit.
// RULE8: Reset is active low, release synchronised to the core clock.
module rfp_top (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  rfp_pkg::rfp_flag_cmd_s flag_cmd,
	input  wire logic          bscan_active,
	input  wire logic [15:0]   pull_disable_reg_two,
	input  wire logic          tck,
	input  wire logic          tms_in,
	output logic               external_flag_out,
	output logic               external_flag_oe_n,
	output rfp_pkg::rfp_core_ctl_s core_ctl,
	output logic               rst_pullup_en,
	output logic               tms_pullup_en,
	output logic               tms_sample,
	output logic               tck_rise
);
	import rfp_pkg::*;

	// ------------------------------------------------------------------
	// Reset release synchroniser
	// ------------------------------------------------------------------
	logic rel_s1_q, rel_s1_d, rel_s2_q, rel_s2_d;
	// Release ripples through two stages before the sequencer sees it
	always_comb begin
		rel_s1_d = 1'h1;
		rel_s2_d = rel_s1_q;
	end
	// Reset clears both stages, so every release starts from a clean edge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rel_s1_q <= 1'h0; // [RULE8]
			rel_s2_q <= 1'h0;
		end else begin
			rel_s1_q <= rel_s1_d;
			rel_s2_q <= rel_s2_d;
		end
	end

	// ------------------------------------------------------------------
	// Execution sequencer
	// ------------------------------------------------------------------
	rfp_state_e    st_q, st_d;
	rfp_core_ctl_s ctl_q, ctl_d;
	// Next state and core controls; the pulses default low every cycle
	always_comb begin
		st_d  = st_q;
		ctl_d = ctl_q;
		ctl_d.fetch_start = 1'h0;
		ctl_d.pc_load     = 1'h0;
		case (st_q)
			RFP_HELD: begin
				ctl_d.halt     = 1'h1;
				ctl_d.pc_load  = 1'h1; // [RULE3]
				ctl_d.pc_value = `RFP_RESET_VECTOR;
				if (rel_s2_q)
					st_d = RFP_RELEASE; // [RULE8]
			end
			RFP_RELEASE: begin
				// Release and vector fetch share one clean edge
				ctl_d.halt        = 1'h0;
				ctl_d.fetch_start = 1'h1; // [RULE4]
				st_d              = RFP_RUN;
			end
			RFP_RUN: begin
				ctl_d.halt = 1'h0;
			end
			default: begin
				st_d = RFP_HELD;
			end
		endcase
	end
	// Reset parks the core on the vector with execution halted
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q           <= RFP_HELD; // [RULE3]
			ctl_q.halt     <= 1'h1;
			ctl_q.pc_load  <= 1'h1;
			ctl_q.pc_value <= `RFP_RESET_VECTOR;
			ctl_q.fetch_start <= 1'h0;
		end else begin
			st_q  <= st_d;
			ctl_q <= ctl_d;
		end
	end
	assign core_ctl = ctl_q;

	// ------------------------------------------------------------------
	// External flag and its enable
	// ------------------------------------------------------------------
	// Clear wins when commands collide, matching the low-going paths
	logic flag_q, flag_d, oe_n_q, oe_n_d, clr;
	always_comb begin
		clr = flag_cmd.clr_instr | (flag_cmd.st1_wr &
			~flag_cmd.st1_data[`RFP_ST1_FLAG_BIT]);
		flag_d = flag_q;
		if (ctl_q.halt)
			flag_d = `RFP_FLAG_RST_VAL;
		else if (clr)
			flag_d = 1'h0; // [RULE1]
		else if (flag_cmd.set_instr)
			flag_d = 1'h1; // [RULE1]
		oe_n_d = bscan_active; // [RULE2]
	end
	// Pin level and its enable both leave straight from flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flag_q <= `RFP_FLAG_RST_VAL;
			oe_n_q <= 1'h0;
		end else begin
			flag_q <= flag_d;
			oe_n_q <= oe_n_d;
		end
	end
	assign external_flag_out  = flag_q;
	assign external_flag_oe_n = oe_n_q;

	// ------------------------------------------------------------------
	// Internal pull-up controls
	// ------------------------------------------------------------------
	logic rpu_q, rpu_d, tpu_q, tpu_d;
	// A set disable bit turns the pull-up off, so enables are inverted
	always_comb begin
		rpu_d = ~pull_disable_reg_two[`RFP_PD2_RST_BIT]; // [RULE5]
		tpu_d = ~pull_disable_reg_two[`RFP_PD2_TMS_BIT]; // [RULE7]
	end
	// Reset overrides software so the reset pin cannot float while reset is held
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rpu_q <= 1'h1; // [RULE5]
			tpu_q <= 1'h1;
		end else begin
			rpu_q <= rpu_d;
			tpu_q <= tpu_d;
		end
	end
	assign rst_pullup_en = rpu_q;
	assign tms_pullup_en = tpu_q;

	// ------------------------------------------------------------------
	// Test-mode-select sampling
	// ------------------------------------------------------------------
	// Test clock and mode select are brought into the core clock here
	rfp_tms_sampler u_tms (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.tck        (tck),
		.tms_in     (tms_in),
		.tms_sample (tms_sample),
		.tck_rise   (tck_rise)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// Flag follows the core commands one edge later, clear first
	AST_FLAG_SET: assert property ( // [RULE1]
		@(posedge ref_clk) disable iff (!rst_n)
		flag_cmd.set_instr && !clr && !ctl_q.halt |=> external_flag_out)
		else $error("flag not set");
	AST_FLAG_CLR: assert property ( // [RULE1]
		@(posedge ref_clk) disable iff (!rst_n)
		clr |=> !external_flag_out)
		else $error("flag not cleared");
	AST_FLAG_HOLD: assert property ( // [RULE1]
		@(posedge ref_clk) disable iff (!rst_n)
		!flag_cmd.set_instr && !clr && !ctl_q.halt
		|=> $stable(external_flag_out))
		else $error("flag moved without a command");
	AST_FLAG_OE: assert property ( // [RULE2]
		@(posedge ref_clk) disable iff (!rst_n)
		##1 external_flag_oe_n == $past(bscan_active))
		else $error("flag enable wrong");
	// Reset and release sequence as the core sees it
	AST_HALT_RST: assert property ( // [RULE3]
		@(posedge ref_clk)
		!rst_n |=> core_ctl.halt && core_ctl.pc_value == `RFP_RESET_VECTOR)
		else $error("not halted in reset");
	AST_FLAG_HALT: assert property ( // [RULE3]
		@(posedge ref_clk) disable iff (!rst_n)
		core_ctl.halt |=> !external_flag_out)
		else $error("flag not held low while halted");
	AST_PC_LOAD: assert property ( // [RULE3]
		@(posedge ref_clk) disable iff (!rst_n)
		core_ctl.pc_load |-> core_ctl.halt && core_ctl.pc_value == `RFP_RESET_VECTOR)
		else $error("program counter loaded while running");
	AST_FETCH: assert property ( // [RULE4]
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rel_s2_q) |-> ##2 core_ctl.fetch_start && !core_ctl.halt)
		else $error("vector fetch missing");
	AST_FETCH_ONE: assert property ( // [RULE4]
		@(posedge ref_clk) disable iff (!rst_n)
		core_ctl.fetch_start |=> !core_ctl.fetch_start)
		else $error("vector fetch longer than one cycle");
	AST_SYNC: assert property ( // [RULE8]
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> core_ctl.halt [*4] ##1 !core_ctl.halt)
		else $error("release not synchronised");
	// Pull-up controls and mode select sampling
	AST_RST_PU: assert property ( // [RULE5]
		@(posedge ref_clk)
		!rst_n |=> rst_pullup_en)
		else $error("reset pull-up not forced");
	AST_RST_PU_SW: assert property ( // [RULE5]
		@(posedge ref_clk) disable iff (!rst_n)
		##1 rst_pullup_en == !$past(pull_disable_reg_two[`RFP_PD2_RST_BIT]))
		else $error("reset pull-up ignores its control bit");
	AST_TMS_PU: assert property ( // [RULE7]
		@(posedge ref_clk) disable iff (!rst_n)
		##1 tms_pullup_en == !$past(pull_disable_reg_two[`RFP_PD2_TMS_BIT]))
		else $error("mode select pull-up wrong");
	AST_TMS: assert property ( // [RULE6]
		@(posedge ref_clk) disable iff (!rst_n)
		!tck_rise |=> $stable(tms_sample) || tck_rise)
		else $error("mode select sampled off edge");
	// Main scenarios: release, flag both ways, scan and test clock
	COV_FETCH: cover property (@(posedge ref_clk) core_ctl.fetch_start);
	COV_SET: cover property (@(posedge ref_clk) $rose(external_flag_out));
	COV_CLR: cover property (@(posedge ref_clk) $fell(external_flag_out));
	COV_SCAN: cover property (@(posedge ref_clk) external_flag_oe_n);
	COV_TCK: cover property (@(posedge ref_clk) tck_rise);
endmodule

// ==== design/rfp_regs.svh ====
// Constants for the reset, flag and test-mode-select pin block
`ifndef RFP_REGS_SVH
`define RFP_REGS_SVH
`define RFP_RESET_VECTOR   24'hFFFF00
`define RFP_ST1_FLAG_BIT   13
`define RFP_PD2_RST_BIT    0
`define RFP_PD2_TMS_BIT    1
`define RFP_FLAG_RST_VAL   1'h0
`define RFP_SYNC_STAGES    2
`endif

// ==== design/rfp_pkg.sv ====
// Types shared by the reset, flag and test-mode-select pin block
package rfp_pkg;
	typedef logic [23:0] rfp_addr_t;
	typedef logic [15:0] rfp_word_t;

	// Flag commands from the core
	typedef struct packed {
		logic      set_instr;
		logic      clr_instr;
		logic      st1_wr;
		rfp_word_t st1_data;
	} rfp_flag_cmd_s;

	// Core control derived from reset
	typedef struct packed {
		logic      halt;
		logic      pc_load;
		rfp_addr_t pc_value;
		logic      fetch_start;
	} rfp_core_ctl_s;

	typedef enum logic [1:0] {
		RFP_HELD    = 2'h0,
		RFP_RELEASE = 2'h1,
		RFP_RUN     = 2'h2
	} rfp_state_e;
endpackage

// ==== design/rfp_tms_sampler.sv ====
// Samples the test-mode-select input on rising edges of the test clock
`timescale 1ns/1ps
module rfp_tms_sampler (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic tck,
	input  wire logic tms_in,
	output logic      tms_sample,
	output logic      tck_rise
);
	logic tck_s1_q, tck_s2_q, tck_s3_q;
	logic tms_s1_q, tms_s2_q, tms_s3_q;
	logic rise;

	// --------------------------------------------------------------
	// Synchronise test clock and mode select together
	// --------------------------------------------------------------
	// Mode select goes one stage deeper than the test clock edge detect so the sample sees settled mode select
	assign rise = tck_s2_q & ~tck_s3_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tck_s1_q   <= 1'h0;
			tck_s2_q   <= 1'h0;
			tck_s3_q   <= 1'h0;
			tms_s1_q   <= 1'h1;
			tms_s2_q   <= 1'h1;
			tms_s3_q   <= 1'h1;
			tms_sample <= 1'h1;
			tck_rise   <= 1'h0;
		end else begin
			tck_s1_q   <= tck;
			tck_s2_q   <= tck_s1_q;
			tck_s3_q   <= tck_s2_q;
			tms_s1_q   <= tms_in;
			tms_s2_q   <= tms_s1_q;
			tms_s3_q   <= tms_s2_q;
			tck_rise   <= rise;
			if (rise)
				tms_sample <= tms_s3_q; // [RULE6]
		end
	end
endmodule

// ==== sim/rfp_emu_model.sv ====
// Scan emulator model driving the test clock, mode select and scan flag
`timescale 1ns/1ps
module rfp_emu_model (
	input  wire logic ref_clk,
	input  wire logic run,
	output logic      tck,
	output logic      tms,
	output logic      scan_on,
	output logic      tms_at_rise,
	output int        rises
);
	int ph;

	initial begin
		tck = 1'h0;
		tms = 1'h1;
		scan_on = 1'h0;
		tms_at_rise = 1'h1;
		ph = 0;
		rises = 0;
	end

	// Test clock idles low between frames; mode select rests at pull-up
	// Mode select changes only as the clock falls, so it is stable 6
	// cycles either side of each rise
	always @(negedge ref_clk) begin
		if (!run) begin
			tck <= 1'h0;
			tms <= 1'h1;
			scan_on <= 1'h0;
			ph <= 0;
		end else begin
			scan_on <= 1'h1;
			ph <= (ph + 1) % 12;
			tck <= (ph >= 6);
			if (ph == 0)
				tms <= 1'($urandom);
			if (ph == 6) begin
				tms_at_rise <= tms;
				rises <= rises + 1;
			end
		end
	end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the flag, reset and mode select pin block
`timescale 1ns/1ps
module tb_top;
	import rfp_pkg::*;
	logic          ref_clk, rst_n, tck, tms_in, bsc, run, go;
	logic          flag, oe_n, rpu, tpu, tsm, trise, tms_r;
	logic          e_flag, e_oe, e_rpu, e_tpu;
	logic [15:0]   pd;
	rfp_flag_cmd_s cmd;
	rfp_core_ctl_s ctl;
	int            errors, cmp_count, rises, seen, cnt;

	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end

	rfp_top u_rfp_top (.ref_clk(ref_clk), .rst_n(rst_n),
		.flag_cmd(cmd), .bscan_active(bsc),
		.pull_disable_reg_two(pd), .tck(tck), .tms_in(tms_in),
		.external_flag_out(flag), .external_flag_oe_n(oe_n),
		.core_ctl(ctl), .rst_pullup_en(rpu), .tms_pullup_en(tpu),
		.tms_sample(tsm), .tck_rise(trise));

	rfp_emu_model u_rfp_emu_model (.ref_clk(ref_clk), .run(run),
		.tck(tck), .tms(tms_in), .scan_on(bsc),
		.tms_at_rise(tms_r), .rises(rises));

	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task end_of_test;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------
	// Reference model, one edge behind the inputs
	// ------------------------------------------------
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt <= 0;
			e_flag <= 1'h0;
			e_oe <= 1'h0;
			e_rpu <= 1'h1;
			e_tpu <= 1'h1;
		end else begin
			cnt <= (cnt < 5) ? cnt + 1 : cnt;
			e_oe <= bsc;
			e_rpu <= ~pd[0];
			e_tpu <= ~pd[1];
			// Clear wins over set; halt drops after the fourth edge,
			// so commands count from the fifth edge on
			if (cnt >= 4) begin
				if (cmd.clr_instr | (cmd.st1_wr & ~cmd.st1_data[13]))
					e_flag <= 1'h0;
				else if (cmd.set_instr)
					e_flag <= 1'h1;
			end
		end
	end

	// Compare the settled outputs once per cycle; pc_value only while loading, mode select sample only on a rise or at cnt 0
	always @(negedge ref_clk) begin
		if (go) begin
			chk(flag, e_flag);
			chk(oe_n, e_oe);
			chk(ctl.halt, cnt < 4);
			chk(ctl.pc_load, cnt < 4);
			if (ctl.pc_load)
				chk(ctl.pc_value, 24'hFFFF00);
			chk(ctl.fetch_start, cnt == 4);
			chk(rpu, e_rpu);
			chk(tpu, e_tpu);
			if (cnt == 0)
				chk({tsm, trise}, 2'h2);
			if (trise) begin
				seen++;
				chk(tsm, tms_r);
			end
		end
	end

	// Random flag commands and pull settings, one set per cycle
	task rnd(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			cmd.set_instr = ($urandom % 3 == 0);
			cmd.clr_instr = ($urandom % 5 == 0);
			cmd.st1_wr = ($urandom % 4 == 0);
			cmd.st1_data = 16'($urandom);
			pd = 16'($urandom);
		end
	endtask

	initial begin
		errors = 0;
		cmp_count = 0;
		seen = 0;
		go = 1'h0;
		rst_n = 1'h0;
		run = 1'h0;
		pd = 16'h0000;
		cmd = '0;
		void'($urandom(32'h87C6));
		repeat (2) @(negedge ref_clk);
		go <= 1'h1;
		rnd(4);
		rst_n = 1'h1;
		rnd(200);
		run <= 1'h1;
		rnd(240);
		run <= 1'h0;
		rnd(20);
		// Reset after the scan run has stopped, while commands keep arriving
		rst_n = 1'h0;
		rnd(3);
		rst_n = 1'h1;
		rnd(100);
		chk(seen, rises);
		end_of_test;
	end

	// Hang guard, well beyond the 569 cycles of stimulus
	initial begin
		#200000;
		errors++;
		end_of_test;
	end
endmodule
